/* dsp_cpu_register_file.sv */
`timescale 1ns/1ps
module dsp_cpu_register_file
    import reg_file_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              gpr_we,
    input  wire logic [GPR_AW-1:0] gpr_waddr,
    input  wire logic [XLEN-1:0]   gpr_wdata,
    input  wire logic [GPR_AW-1:0] rd_a_addr,
    input  wire logic [GPR_AW-1:0] rd_b_addr,
    output logic      [XLEN-1:0]   rd_a_data,
    output logic      [XLEN-1:0]   rd_b_data,
    output logic      [XLEN-1:0]   index_r0,
    output logic      [XLEN-1:0]   stack_pointer,
    input  wire logic              exc_entry,
    input  wire logic              exc_return,
    input  wire logic [XLEN-1:0]   exc_status_in,
    input  wire logic              x_ptr_sel,
    input  wire logic              y_ptr_sel,
    input  wire logic [1:0]        single_ptr_sel,
    output logic      [XLEN-1:0]   x_pointer,
    output logic      [XLEN-1:0]   x_index,
    output logic      [XLEN-1:0]   y_pointer,
    output logic      [XLEN-1:0]   y_index,
    output logic      [XLEN-1:0]   single_pointer,
    output logic      [XLEN-1:0]   single_index,
    output logic                   x_ring_enable,
    output logic                   y_ring_enable,
    output logic                   ring_conflict,
    output logic      [15:0]       ring_end,
    output logic      [15:0]       ring_begin,
    input  wire logic [2:0]        ctl_op,
    input  wire logic [2:0]        ctl_sel,
    input  wire logic [GPR_AW-1:0] ctl_gpr,
    input  wire logic [XLEN-1:0]   ctl_mem_rdata,
    output logic                   ctl_mem_we,
    output logic      [XLEN-1:0]   ctl_mem_addr,
    output logic      [XLEN-1:0]   ctl_mem_wdata,
    input  wire logic              loop_addr_we,
    input  wire logic              loop_addr_end,
    input  wire logic [DISP_W-1:0] loop_disp,
    input  wire logic [XLEN-1:0]   pc,
    input  wire logic              loop_count_dec,
    input  wire logic              t_we,
    input  wire logic              t_in,
    input  wire logic              div_we,
    input  wire logic              div_m_in,
    input  wire logic              div_q_in,
    input  wire logic [3:0]        irq_level,
    output logic                   irq_accept,
    output logic      [XLEN-1:0]   processor_status_word,
    output logic      [XLEN-1:0]   global_base,
    output logic      [XLEN-1:0]   vector_base,
    output logic      [XLEN-1:0]   loop_start_addr,
    output logic      [XLEN-1:0]   loop_end_addr,
    output logic      [XLEN-1:0]   ring_bounds,
    output logic      [XLEN-1:0]   dsp_condition,
    output logic      [11:0]       loop_count,
    output logic                   loop_count_valid,
    output logic      [2:0]        loop_steps,
    input  wire logic              dsp_we,
    input  wire logic [DSP_AW-1:0] dsp_waddr,
    input  wire logic [ACC_W-1:0]  dsp_wdata,
    input  wire logic [DSP_AW-1:0] dsp_raddr,
    output logic      [ACC_W-1:0]  dsp_rdata
);

    logic [XLEN-1:0]  gpr_q [GPR_COUNT];
    logic [XLEN-1:0]  status_q;
    logic [XLEN-1:0]  global_q;
    logic [XLEN-1:0]  vector_q;
    logic [XLEN-1:0]  lstart_q;
    logic [XLEN-1:0]  lend_q;
    logic [XLEN-1:0]  ring_q;
    logic [XLEN-1:0]  dcond_q;
    logic [ACC_W-1:0] dsp_q [DSP_COUNT];
    logic [XLEN-1:0]  ctl_val;
    logic [XLEN-1:0]  ctl_src;
    logic [XLEN-1:0]  ctl_gpr_val;
    logic [XLEN-1:0]  loop_target;
    logic             ctl_wr;

    assign ctl_gpr_val = gpr_q[ctl_gpr];
    assign ctl_wr      = (ctl_op == OP_COPY_IN) || (ctl_op == OP_LOAD_IN);
    // register copy takes the general register, load takes memory data
    assign ctl_src     = (ctl_op == OP_LOAD_IN) ? ctl_mem_rdata : ctl_gpr_val;
    // displacement doubled and added to the program counter
    assign loop_target = pc + (XLEN'(signed'(loop_disp)) << DISP_SHL);

    // selected control register for outward moves
    always_comb begin
        unique case (ctl_sel)
            CTL_STATUS: ctl_val = status_q;
            CTL_GLOBAL: ctl_val = global_q;
            CTL_VECTOR: ctl_val = vector_q;
            CTL_LSTART: ctl_val = lstart_q;
            CTL_LEND:   ctl_val = lend_q;
            CTL_RING:   ctl_val = ring_q;
            CTL_DCOND:  ctl_val = dcond_q;
            default:    ctl_val = WORD_RESET;
        endcase
    end

    // general registers; the direct write port is applied last and wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < GPR_COUNT; i++) begin
                gpr_q[i] <= WORD_RESET;
            end
        end else begin
            if (exc_entry) begin
                gpr_q[IDX_SP] <= gpr_q[IDX_SP] - EXC_FRAME;
            end else if (exc_return) begin
                gpr_q[IDX_SP] <= gpr_q[IDX_SP] + EXC_FRAME;
            end
            unique case (ctl_op)
                OP_LOAD_IN:  gpr_q[ctl_gpr] <= ctl_gpr_val + PTR_STEP;
                OP_STORE:    gpr_q[ctl_gpr] <= ctl_gpr_val - PTR_STEP;
                OP_COPY_OUT: gpr_q[ctl_gpr] <= ctl_val;
                default:     ;
            endcase
            if (gpr_we) begin
                gpr_q[gpr_waddr] <= gpr_wdata;
            end
        end
    end

    // status word: software moves beat flag updates; reserved bits stay zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= STATUS_RESET;
        end else if (exc_return) begin
            status_q <= exc_status_in & STATUS_WMASK;
        end else if (ctl_wr && ctl_sel == CTL_STATUS) begin
            status_q <= ctl_src & STATUS_WMASK;
        end else begin
            if (t_we) begin
                status_q[TFLAG] <= t_in;
            end
            if (div_we) begin
                status_q[DIV_M] <= div_m_in;
                status_q[DIV_Q] <= div_q_in;
            end
            if (loop_count_dec && status_q[RC_MSB:RC_LSB] != '0) begin
                status_q[RC_MSB:RC_LSB] <= status_q[RC_MSB:RC_LSB] - COUNT_ONE;
            end
        end
    end

    // base registers and the condition register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            global_q <= WORD_RESET;
            vector_q <= WORD_RESET;
            dcond_q  <= WORD_RESET;
        end else if (ctl_wr) begin
            if (ctl_sel == CTL_GLOBAL) global_q <= ctl_src;
            if (ctl_sel == CTL_VECTOR) vector_q <= ctl_src;
            if (ctl_sel == CTL_DCOND)  dcond_q  <= ctl_src;
        end
    end

    // loop and ring registers: loop address writes beat control moves
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lstart_q <= WORD_RESET;
            lend_q   <= WORD_RESET;
            ring_q   <= WORD_RESET;
        end else if (loop_addr_we) begin
            // stored as computed; the fetch unit maps them to the loop body
            if (loop_addr_end) lend_q <= loop_target;
            else lstart_q <= loop_target;
        end else if (ctl_wr) begin
            if (ctl_sel == CTL_LSTART) lstart_q <= ctl_src;
            if (ctl_sel == CTL_LEND)   lend_q   <= ctl_src;
            if (ctl_sel == CTL_RING)   ring_q   <= ctl_src;
        end
    end

    // store move: pointer decremented first, then the word goes out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_mem_we    <= 1'b0;
            ctl_mem_addr  <= WORD_RESET;
            ctl_mem_wdata <= WORD_RESET;
        end else begin
            ctl_mem_we <= (ctl_op == OP_STORE);
            if (ctl_op == OP_STORE) begin
                ctl_mem_addr  <= ctl_gpr_val - PTR_STEP;
                ctl_mem_wdata <= ctl_val;
            end
        end
    end

    // data registers: the two wide ones keep guard bits, the rest drop them
    for (genvar g = 0; g < DSP_COUNT; g++) begin : g_dsp
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                dsp_q[g] <= '0;
            end else if (dsp_we && dsp_waddr == DSP_AW'(g)) begin
                if (g < WIDE_CNT) dsp_q[g] <= dsp_wdata;
                else dsp_q[g] <= {{GUARD_W{1'b0}}, dsp_wdata[XLEN-1:0]};
            end
        end
    end

    // registered read ports; a write is seen one cycle after it lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_a_data     <= WORD_RESET;
            rd_b_data     <= WORD_RESET;
            index_r0      <= WORD_RESET;
            stack_pointer <= WORD_RESET;
            dsp_rdata     <= '0;
        end else begin
            rd_a_data     <= gpr_q[rd_a_addr];
            rd_b_data     <= gpr_q[rd_b_addr];
            index_r0      <= gpr_q[IDX_INDEX];
            stack_pointer <= gpr_q[IDX_SP];
            dsp_rdata     <= dsp_q[dsp_raddr];
        end
    end

    // all pointer groups read together for parallel transfers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            x_pointer      <= WORD_RESET;
            x_index        <= WORD_RESET;
            y_pointer      <= WORD_RESET;
            y_index        <= WORD_RESET;
            single_pointer <= WORD_RESET;
            single_index   <= WORD_RESET;
        end else begin
            x_pointer      <= gpr_q[IDX_XPTR + 4'(x_ptr_sel)];
            x_index        <= gpr_q[IDX_XIDX];
            y_pointer      <= gpr_q[IDX_YPTR + 4'(y_ptr_sel)];
            y_index        <= gpr_q[IDX_YIDX];
            single_pointer <= gpr_q[IDX_SPTR + 4'(single_ptr_sel)];
            single_index   <= gpr_q[IDX_XIDX];
        end
    end

    // ring controls; the single path carries no ring enable at all
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            x_ring_enable <= 1'b0;
            y_ring_enable <= 1'b0;
            ring_conflict <= 1'b0;
            ring_end      <= '0;
            ring_begin    <= '0;
        end else begin
            x_ring_enable <= status_q[XRING];
            y_ring_enable <= status_q[YRING];
            // both set is a software fault, flagged rather than resolved
            ring_conflict <= status_q[XRING] & status_q[YRING];
            ring_end      <= ring_q[31:16];
            ring_begin    <= ring_q[15:0];
        end
    end

    // status and control views
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            processor_status_word <= STATUS_RESET;
            global_base           <= WORD_RESET;
            vector_base           <= WORD_RESET;
            loop_start_addr       <= WORD_RESET;
            loop_end_addr         <= WORD_RESET;
            ring_bounds           <= WORD_RESET;
            dsp_condition         <= WORD_RESET;
            loop_count            <= '0;
            loop_count_valid      <= 1'b0;
            irq_accept            <= 1'b0;
        end else begin
            processor_status_word <= status_q & STATUS_WMASK;
            global_base           <= global_q;
            vector_base           <= vector_q;
            loop_start_addr       <= lstart_q;
            loop_end_addr         <= lend_q;
            ring_bounds           <= ring_q;
            dsp_condition         <= dcond_q;
            loop_count            <= status_q[RC_MSB:RC_LSB];
            loop_count_valid      <= status_q[RC_MSB:RC_LSB] >= COUNT_MIN;
            // request taken only when its level is above the mask
            irq_accept <= irq_level > status_q[MASK_MSB:MASK_LSB];
        end
    end

    // loop body length decode; 4 stands for four or more
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_steps <= 3'h1;
        end else begin
            unique case (status_q[LEN_MSB:LEN_LSB])
                LEN_ONE:   loop_steps <= 3'h1;
                LEN_TWO:   loop_steps <= 3'h2;
                LEN_THREE: loop_steps <= 3'h3;
                LEN_MORE:  loop_steps <= 3'h4;
            endcase
        end
    end

    // saturation enable leaves only through the status view; no separate pin
endmodule

/* reg_file_pkg.sv */
package reg_file_pkg;
    // widths and counts
    localparam int XLEN      = 32;
    localparam int GPR_COUNT = 16;
    localparam int GPR_AW    = 4;
    localparam int DSP_COUNT = 8;
    localparam int DSP_AW    = 3;
    localparam int ACC_W     = 40;
    localparam int GUARD_W   = 8;
    localparam int WIDE_CNT  = 2;
    localparam int DISP_W    = 8;
    localparam int DISP_SHL  = 1;

    // fixed general register roles
    localparam logic [3:0] IDX_INDEX = 4'h0;
    localparam logic [3:0] IDX_SP    = 4'hf;
    localparam logic [3:0] IDX_SPTR  = 4'h2;
    localparam logic [3:0] IDX_XPTR  = 4'h4;
    localparam logic [3:0] IDX_YPTR  = 4'h6;
    localparam logic [3:0] IDX_XIDX  = 4'h8;
    localparam logic [3:0] IDX_YIDX  = 4'h9;

    // status word fields
    localparam int RC_LSB   = 16;
    localparam int RC_MSB   = 27;
    localparam int YRING    = 11;
    localparam int XRING    = 10;
    localparam int DIV_M    = 9;
    localparam int DIV_Q    = 8;
    localparam int MASK_LSB = 4;
    localparam int MASK_MSB = 7;
    localparam int LEN_LSB  = 2;
    localparam int LEN_MSB  = 3;
    localparam int SAT      = 1;
    localparam int TFLAG    = 0;
    localparam logic [31:0] STATUS_WMASK = 32'h0fff_0fff;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    localparam logic [11:0] COUNT_MIN    = 12'h002;
    localparam logic [11:0] COUNT_ONE    = 12'h001;

    // loop body length codes
    localparam logic [1:0] LEN_ONE   = 2'b00;
    localparam logic [1:0] LEN_TWO   = 2'b01;
    localparam logic [1:0] LEN_THREE = 2'b11;
    localparam logic [1:0] LEN_MORE  = 2'b10;

    // pointer steps
    localparam logic [31:0] PTR_STEP  = 32'h0000_0004;
    localparam logic [31:0] EXC_FRAME = 32'h0000_0008;

    // control register selects
    localparam logic [2:0] CTL_STATUS = 3'h0;
    localparam logic [2:0] CTL_GLOBAL = 3'h1;
    localparam logic [2:0] CTL_VECTOR = 3'h2;
    localparam logic [2:0] CTL_LSTART = 3'h3;
    localparam logic [2:0] CTL_LEND   = 3'h4;
    localparam logic [2:0] CTL_RING   = 3'h5;
    localparam logic [2:0] CTL_DCOND  = 3'h6;

    // control move operations
    localparam logic [2:0] OP_NONE     = 3'h0;
    localparam logic [2:0] OP_COPY_IN  = 3'h1;
    localparam logic [2:0] OP_LOAD_IN  = 3'h2;
    localparam logic [2:0] OP_COPY_OUT = 3'h3;
    localparam logic [2:0] OP_STORE    = 3'h4;
endpackage

/* dsp_cpu_register_file_assertions.sv */
`timescale 1ns/1ps
module dsp_cpu_register_file_assertions
    import reg_file_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              gpr_we,
    input wire logic [2:0]        ctl_op,
    input wire logic              exc_entry,
    input wire logic              exc_return,
    input wire logic [3:0]        irq_level,
    input wire logic              irq_accept,
    input wire logic [XLEN-1:0]   stack_pointer,
    input wire logic [XLEN-1:0]   processor_status_word,
    input wire logic [XLEN-1:0]   ring_bounds,
    input wire logic [15:0]       ring_end,
    input wire logic [15:0]       ring_begin,
    input wire logic              x_ring_enable,
    input wire logic              y_ring_enable,
    input wire logic              ring_conflict,
    input wire logic [11:0]       loop_count,
    input wire logic              loop_count_valid,
    input wire logic [2:0]        loop_steps,
    input wire logic              ctl_mem_we
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // nothing else may touch the stack pointer while the frame step lands
    sequence s_quiet;
        !gpr_we && !exc_entry && !exc_return && ctl_op == OP_NONE;
    endsequence
    sequence s_push;
        exc_entry && !exc_return && !gpr_we && ctl_op == OP_NONE;
    endsequence
    property p_push_frame;
        s_push ##1 s_quiet |=> stack_pointer == $past(stack_pointer) - EXC_FRAME;
    endproperty
    a_push_frame: assert property (p_push_frame) else $error("stack frame step wrong");

    property p_reserved_zero;
        (processor_status_word & ~STATUS_WMASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_ring_halves;
        ring_end == ring_bounds[31:16] && ring_begin == ring_bounds[15:0];
    endproperty
    a_ring_halves: assert property (p_ring_halves) else $error("ring halves wrong");

    property p_ring_enables;
        x_ring_enable == processor_status_word[XRING] && y_ring_enable ==
        processor_status_word[YRING] && ring_conflict == (x_ring_enable && y_ring_enable);
    endproperty
    a_ring_enables: assert property (p_ring_enables) else $error("ring enables wrong");

    property p_count_field;
        loop_count == processor_status_word[RC_MSB:RC_LSB] &&
        loop_count_valid == (loop_count >= COUNT_MIN);
    endproperty
    a_count_field: assert property (p_count_field) else $error("loop count wrong");

    property p_loop_steps;
        loop_steps == (processor_status_word[LEN_MSB:LEN_LSB] == LEN_ONE ? 3'h1 :
                       processor_status_word[LEN_MSB:LEN_LSB] == LEN_TWO ? 3'h2 :
                       processor_status_word[LEN_MSB:LEN_LSB] == LEN_THREE ? 3'h3 : 3'h4);
    endproperty
    a_loop_steps: assert property (p_loop_steps) else $error("loop steps wrong");

    // settled level and mask only; the accept flag lags a changing level
    property p_irq_accept;
        ($stable(irq_level) && $stable(processor_status_word))[*3] |->
        irq_accept == (irq_level > processor_status_word[MASK_MSB:MASK_LSB]);
    endproperty
    a_irq_accept: assert property (p_irq_accept) else $error("irq accept wrong");

    property p_store_pulse;
        ctl_op == OP_STORE |=> ctl_mem_we;
    endproperty
    a_store_pulse: assert property (p_store_pulse) else $error("store missing");

    property p_no_stray_store;
        ctl_op != OP_STORE |=> !ctl_mem_we;
    endproperty
    a_no_stray_store: assert property (p_no_stray_store) else $error("stray store");
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top
    import reg_file_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              gpr_we, exc_entry, exc_return, x_ptr_sel, y_ptr_sel, st_we;
    logic              loop_addr_we, loop_addr_end, loop_count_dec, t_we, t_in;
    logic              div_we, div_m_in, div_q_in, dsp_we, ctl_mem_we;
    logic              irq_accept, x_ring_enable, y_ring_enable, ring_conflict, loop_count_valid;
    logic [GPR_AW-1:0] gpr_waddr, rd_a_addr, rd_b_addr, ctl_gpr;
    logic [XLEN-1:0]   gpr_wdata, rd_a_data, rd_b_data, index_r0, stack_pointer, exc_status_in;
    logic [XLEN-1:0]   x_pointer, x_index, y_pointer, y_index, single_pointer, single_index;
    logic [XLEN-1:0]   ctl_mem_rdata, ctl_mem_addr, ctl_mem_wdata, pc, processor_status_word;
    logic [XLEN-1:0]   global_base, vector_base, loop_start_addr, loop_end_addr, ring_bounds;
    logic [XLEN-1:0]   dsp_condition, w, st_addr, st_data;
    logic [15:0]       ring_end, ring_begin;
    logic [11:0]       loop_count;
    logic [3:0]        irq_level;
    logic [2:0]        ctl_op, ctl_sel, loop_steps;
    logic [1:0]        single_ptr_sel;
    logic [DISP_W-1:0] loop_disp;
    logic [DSP_AW-1:0] dsp_waddr, dsp_raddr;
    logic [ACC_W-1:0]  dsp_wdata, dsp_rdata;
    logic [11:0]       cnts [4] = '{12'h000, 12'h001, 12'h002, 12'hfff};
    logic [1:0]        codes [4] = '{LEN_ONE, LEN_TWO, LEN_THREE, LEN_MORE};
    logic [2:0]        steps [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    int                failures = 0;
    int                total_checks = 0;

    dsp_cpu_register_file uut (.*);

    always #5 clk = ~clk;

    // distinct per-register pattern so a wrong index shows up
    function automatic logic [31:0] pat(input int i);
        return 32'ha5a5_0000 ^ {4{i[7:0]}};
    endfunction
    function automatic logic [31:0] ed(input int i);
        return pat(i) ^ 32'h5a00_0000;
    endfunction

    task automatic nxt(input int n = 1);
        repeat (n) @(negedge clk);
    endtask
    // one idle cycle after each command keeps drivers from double assignment
    task automatic pulse(ref logic s);
        s = 1'b1;
        nxt();
        s = 1'b0;
        nxt();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        gpr_waddr = a;
        gpr_wdata = d;
        pulse(gpr_we);
    endtask
    task automatic chk_gpr(input logic [3:0] a, input logic [31:0] e);
        rd_a_addr = a;
        rd_b_addr = a;
        nxt();
        `CHK(rd_a_data, e)
        `CHK(rd_b_data, e)
    endtask
    // store outputs stand one cycle, so they are caught at the first negedge
    task automatic ctl(input logic [2:0] op, s, input logic [3:0] g, input logic [31:0] m);
        ctl_op = op;
        ctl_sel = s;
        ctl_gpr = g;
        ctl_mem_rdata = m;
        nxt();
        {st_we, st_addr, st_data} = {ctl_mem_we, ctl_mem_addr, ctl_mem_wdata};
        ctl_op = OP_NONE;
        nxt();
    endtask

    task automatic summarize();
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        summarize();
    end

    initial begin
        {gpr_we, exc_entry, exc_return, x_ptr_sel, y_ptr_sel, loop_addr_we, loop_addr_end,
         loop_count_dec, t_we, t_in, div_we, div_m_in, div_q_in, dsp_we, gpr_waddr, rd_a_addr,
         rd_b_addr, ctl_gpr, gpr_wdata, exc_status_in, ctl_mem_rdata, pc, irq_level, ctl_op,
         ctl_sel, single_ptr_sel, loop_disp, dsp_waddr, dsp_raddr, dsp_wdata} = '0;
        nxt(2);
        `CHK(processor_status_word, STATUS_RESET)
        `CHK(loop_steps, 3'h1)
        rst_b = 1'b1;
        for (int i = 0; i < 16; i++) wr(i[3:0], pat(i));
        for (int i = 0; i < 16; i++) chk_gpr(i[3:0], pat(i));
        `CHK(index_r0, pat(0))
        `CHK(stack_pointer, pat(15))
        // every pointer selection, all groups read together
        for (int s = 0; s < 4; s++) begin
            x_ptr_sel = s[0];
            y_ptr_sel = s[0];
            single_ptr_sel = s[1:0];
            nxt(2);
            `CHK(x_pointer, pat(4 + s[0]))
            `CHK(x_index, pat(8))
            `CHK(y_pointer, pat(6 + s[0]))
            `CHK(y_index, pat(9))
            `CHK(single_pointer, pat(2 + s))
            `CHK(single_index, pat(8))
        end
        exc_status_in = 32'hffff_ffff;
        pulse(exc_entry);
        `CHK(stack_pointer, pat(15) - EXC_FRAME)
        pulse(exc_return);
        `CHK(stack_pointer, pat(15))
        `CHK(processor_status_word, STATUS_WMASK)
        `CHK(ring_conflict, 1'b1)
        // each loop length code, count boundaries and mask edge
        for (int c = 0; c < 4; c++) begin
            w = {4'h0, cnts[c], 4'h0, ~c[0], c[0], 2'b10, 4'h7, codes[c], c[0], ~c[0]};
            irq_level = 4'h7 + 4'(c[0]);
            wr(4'h1, w | 32'hf000_f000);
            ctl(OP_COPY_IN, CTL_STATUS, 4'h1, 32'h0);
            `CHK(processor_status_word, w)
            `CHK(loop_steps, steps[c])
            `CHK(loop_count, cnts[c])
            `CHK(loop_count_valid, c[1])
            `CHK(x_ring_enable, c[0])
            `CHK(y_ring_enable, ~c[0])
            `CHK(processor_status_word[SAT], c[0])
            `CHK(irq_accept, c[0])
        end
        wr(4'h1, 32'h0002_0000);
        ctl(OP_COPY_IN, CTL_STATUS, 4'h1, 32'h0);
        pulse(loop_count_dec);
        `CHK(loop_count_valid, 1'b0)
        pulse(loop_count_dec);
        pulse(loop_count_dec);
        `CHK(loop_count, 12'h000)
        t_in = 1'b1;
        div_m_in = 1'b1;
        pulse(t_we);
        pulse(div_we);
        `CHK(processor_status_word[TFLAG], 1'b1)
        `CHK(processor_status_word[DIV_M:DIV_Q], 2'b10)
        for (int s = 1; s < 7; s++) begin
            wr(4'h1, ed(s));
            ctl(OP_COPY_IN, s[2:0], 4'h1, 32'h0);
            ctl(OP_COPY_OUT, s[2:0], 4'h3, 32'h0);
            chk_gpr(4'h3, ed(s));
        end
        // unused select reads as zero
        ctl(OP_COPY_OUT, 3'h7, 4'h3, 32'h0);
        chk_gpr(4'h3, 32'h0000_0000);
        `CHK(global_base, ed(1))
        `CHK(vector_base, ed(2))
        `CHK(loop_start_addr, ed(3))
        `CHK(loop_end_addr, ed(4))
        `CHK(ring_end, ed(5) >> 16)
        `CHK(ring_begin, ed(5) & 32'h0000_ffff)
        `CHK(dsp_condition, ed(6))
        wr(4'h2, 32'h0000_0100);
        ctl(OP_LOAD_IN, CTL_RING, 4'h2, 32'hbeef_1234);
        `CHK(ring_bounds, 32'hbeef_1234)
        chk_gpr(4'h2, 32'h0000_0104);
        ctl(OP_STORE, CTL_LSTART, 4'h2, 32'h0);
        `CHK({st_we, st_addr, st_data}, {1'b1, 32'h0000_0100, ed(3)})
        chk_gpr(4'h2, 32'h0000_0100);
        pc = 32'h0000_1000;
        loop_disp = 8'hfe;
        pulse(loop_addr_we);
        `CHK(loop_start_addr, 32'h0000_0ffc)
        loop_disp = 8'h10;
        loop_addr_end = 1'b1;
        pulse(loop_addr_we);
        `CHK(loop_end_addr, 32'h0000_1020)
        // wide accumulator keeps guard bits, narrow ones drop them
        dsp_wdata = 40'hab_1234_5678;
        pulse(dsp_we);
        nxt();
        `CHK(dsp_rdata, 40'hab_1234_5678)
        dsp_waddr = 3'h2;
        pulse(dsp_we);
        dsp_raddr = 3'h2;
        nxt();
        `CHK(dsp_rdata, 40'h00_1234_5678)
        summarize();
    end
endmodule

bind dsp_cpu_register_file dsp_cpu_register_file_assertions u_chk (.*);
